// >>> rtl/fpla_pkg.sv
// Purpose: shared types and constants of the float load datapath
// Assumes: word bit 31 is the sign, double result bit 63 is the sign
// Notes: single words arrive in the low 32 bits of the load data bus
package fpla_pkg;

  localparam int REG_W = 5;
  typedef logic [REG_W-1:0] fpla_reg_t;

  localparam logic [4:0] ZERO_REG = 5'h00;
  localparam logic [7:0] SP_EXP_ZERO = 8'h00;
  localparam logic [7:0] SP_EXP_MAX = 8'hff;
  localparam logic [22:0] SP_FRAC_ZERO = 23'h000000;
  localparam logic signed [11:0] DENORM_EXP_START = -12'sh07e;
  localparam logic signed [11:0] DP_EXP_BIAS = 12'sh3ff;
  localparam int PAD_ZEROS = 29;
  localparam int CVT_MAX_CYCLES = 25;

  typedef struct packed {
    logic dbl;
    logic indexed;
    logic update;
    fpla_reg_t tgt;
    fpla_reg_t base_f;
    fpla_reg_t index_f;
    logic [15:0] disp;
    logic [31:0] base_val;
    logic [31:0] index_val;
  } fpla_op_s;

  typedef struct packed {
    logic [31:0] addr;
    logic dbl;
  } fpla_mem_req_s;

  typedef struct packed {
    fpla_reg_t tgt;
    logic [63:0] data;
  } fpla_fpr_wr_s;

  typedef struct packed {
    fpla_reg_t sel;
    logic [31:0] data;
  } fpla_gpr_wr_s;

  typedef enum logic [1:0] {
    CLS_NORM,
    CLS_DENORM,
    CLS_SPECIAL
  } fpla_cls_e;

  // sorts a single word into normalized, denormal or inf/nan/zero
  function automatic fpla_cls_e fpla_classify(input logic [31:0] w);
    if (w[30:23] != SP_EXP_ZERO && w[30:23] != SP_EXP_MAX)
      return CLS_NORM;
    else if (w[30:23] == SP_EXP_ZERO && w[22:0] != SP_FRAC_ZERO)
      return CLS_DENORM;
    else
      return CLS_SPECIAL;
  endfunction : fpla_classify

endpackage : fpla_pkg

// >>> rtl/fpla_sp_cvt.sv
// Purpose: single to double precision conversion of one load word
// Assumes: start is a one-cycle pulse given only while idle
// Notes: denormals take one cycle per normalizing shift
`timescale 1ns/1ps
module fpla_sp_cvt
  import fpla_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input wire logic [31:0] word,
  output logic busy,
  output logic done,
  output logic [63:0] result
);

  typedef enum logic {CV_IDLE, CV_SHIFT} fpla_cv_e;

  fpla_cv_e st_q, st_d;
  logic [52:0] frac_q, frac_d;
  logic signed [11:0] exp_q, exp_d;
  logic sign_q, sign_d;
  logic done_q, done_d;
  logic [63:0] res_q, res_d;
  logic signed [11:0] biased;

  always_comb
  begin
    st_d = st_q;
    frac_d = frac_q;
    exp_d = exp_q;
    sign_d = sign_q;
    done_d = 1'b0;
    res_d = res_q;
    biased = exp_q + DP_EXP_BIAS;
    case (st_q)
      CV_IDLE:
      begin
        if (start)
        begin
          case (fpla_classify(word))
            CLS_NORM:
            begin
              res_d = {word[31:30], {3{~word[30]}}, word[29:0],
                       {PAD_ZEROS{1'b0}}};
              done_d = 1'b1;
            end
            CLS_DENORM:
            begin
              sign_d = word[31];
              exp_d = DENORM_EXP_START;
              frac_d = {1'b0, word[22:0], {PAD_ZEROS{1'b0}}};
              st_d = CV_SHIFT;
            end
            default:
            begin
              res_d = {word[31:30], {3{word[30]}}, word[29:0],
                       {PAD_ZEROS{1'b0}}};
              done_d = 1'b1;
            end
          endcase
        end
      end
      default:
      begin
        if (!frac_q[52])
        begin
          frac_d = {frac_q[51:0], 1'b0};
          exp_d = exp_q - 12'sh001;
        end
        else
        begin
          res_d = {sign_q, biased[10:0], frac_q[51:0]};
          done_d = 1'b1;
          st_d = CV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= CV_IDLE;
      frac_q <= '0;
      exp_q <= '0;
      sign_q <= 1'b0;
      done_q <= 1'b0;
      res_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      frac_q <= frac_d;
      exp_q <= exp_d;
      sign_q <= sign_d;
      done_q <= done_d;
      res_q <= res_d;
    end
  end

  assign busy = (st_q == CV_SHIFT);
  assign done = done_q;
  assign result = res_q;

endmodule : fpla_sp_cvt

// >>> rtl/fpla_load_unit.sv
// Purpose: float load datapath: address forming, load, conversion
// Assumes: decoder supplies base and index register contents
// Notes: one load in flight; assist_en selects trap or hardware
//   normalization for denormal single words
`timescale 1ns/1ps
module fpla_load_unit
  import fpla_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic assist_en,
  input wire logic req_valid,
  input wire fpla_op_s req_op,
  output logic req_ready,
  output logic mem_req_valid,
  output fpla_mem_req_s mem_req,
  input wire logic mem_req_ready,
  input wire logic mem_resp_valid,
  input wire logic [63:0] mem_resp_data,
  output logic mem_resp_ready,
  output logic fpr_wr_valid,
  output fpla_fpr_wr_s fpr_wr,
  output logic gpr_wr_valid,
  output fpla_gpr_wr_s gpr_wr,
  output logic assist_exc
);

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_CVT} fpla_st_e;

  fpla_st_e st_q, st_d;
  fpla_op_s op_q, op_d;
  logic [31:0] ea_q, ea_d;
  logic [31:0] word_q, word_d;
  logic fpr_v_q, fpr_v_d;
  fpla_fpr_wr_s fpr_q, fpr_d;
  logic gpr_v_q, gpr_v_d;
  fpla_gpr_wr_s gpr_q, gpr_d;
  logic assist_q, assist_d;
  logic cvt_start;
  logic cvt_busy;
  logic cvt_done;
  logic [63:0] cvt_result;
  logic resp_fire;
  logic accept;
  fpla_cls_e resp_cls;

  // base selection, offset selection and 32-bit wrapping add
  function automatic logic [31:0] ea_calc(input fpla_op_s op);
    logic [31:0] base;
    logic [31:0] off;
    base = (op.base_f == ZERO_REG) ? 32'h0 : op.base_val;
    off = op.indexed ? op.index_val
                     : {{16{op.disp[15]}}, op.disp};
    ea_calc = base + off;
  endfunction : ea_calc

  assign accept = req_valid && req_ready;
  assign resp_fire = mem_resp_valid && mem_resp_ready;
  assign resp_cls = fpla_classify(mem_resp_data[31:0]);

  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    ea_d = ea_q;
    word_d = word_q;
    fpr_v_d = 1'b0;
    fpr_d = fpr_q;
    gpr_v_d = 1'b0;
    gpr_d = gpr_q;
    assist_d = 1'b0;
    cvt_start = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          op_d = req_op;
          ea_d = ea_calc(req_op);
          st_d = ST_ISSUE;
        end
      end
      ST_ISSUE:
      begin
        if (mem_req_ready)
          st_d = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (resp_fire)
        begin
          word_d = mem_resp_data[31:0];
          if (op_q.dbl)
          begin
            fpr_v_d = 1'b1;
            fpr_d = '{tgt: op_q.tgt, data: mem_resp_data};
            gpr_v_d = op_q.update;
            gpr_d = '{sel: op_q.base_f, data: ea_q};
            st_d = ST_IDLE;
          end
          else if (resp_cls == CLS_DENORM && assist_en)
          begin
            assist_d = 1'b1;
            st_d = ST_IDLE;
          end
          else
          begin
            cvt_start = 1'b1;
            st_d = ST_CVT;
          end
        end
      end
      default:
      begin
        if (cvt_done)
        begin
          fpr_v_d = 1'b1;
          fpr_d = '{tgt: op_q.tgt, data: cvt_result};
          gpr_v_d = op_q.update;
          gpr_d = '{sel: op_q.base_f, data: ea_q};
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= ST_IDLE;
      op_q <= '0;
      ea_q <= '0;
      word_q <= '0;
      fpr_v_q <= 1'b0;
      fpr_q <= '0;
      gpr_v_q <= 1'b0;
      gpr_q <= '0;
      assist_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      op_q <= op_d;
      ea_q <= ea_d;
      word_q <= word_d;
      fpr_v_q <= fpr_v_d;
      fpr_q <= fpr_d;
      gpr_v_q <= gpr_v_d;
      gpr_q <= gpr_d;
      assist_q <= assist_d;
    end
  end

  fpla_sp_cvt u_cvt (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(cvt_start),
    .word(mem_resp_data[31:0]),
    .busy(cvt_busy),
    .done(cvt_done),
    .result(cvt_result)
  );

  assign req_ready = (st_q == ST_IDLE);
  assign mem_req_valid = (st_q == ST_ISSUE);
  assign mem_req = '{addr: ea_q, dbl: op_q.dbl};
  assign mem_resp_ready = (st_q == ST_WAIT);
  assign fpr_wr_valid = fpr_v_q;
  assign fpr_wr = fpr_q;
  assign gpr_wr_valid = gpr_v_q;
  assign gpr_wr = gpr_q;
  assign assist_exc = assist_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  ea_imm_base_a: assert property (
    accept && !req_op.indexed && req_op.base_f != ZERO_REG
    |=> ea_q == $past(req_op.base_val)
        + {{16{$past(req_op.disp[15])}}, $past(req_op.disp)})
    else $error("immediate address wrong");

  ea_imm_zero_a: assert property (
    accept && !req_op.indexed && req_op.base_f == ZERO_REG
    |=> ea_q == {{16{$past(req_op.disp[15])}}, $past(req_op.disp)})
    else $error("zero base immediate address wrong");

  ea_idx_base_a: assert property (
    accept && req_op.indexed && req_op.base_f != ZERO_REG
    |=> ea_q == $past(req_op.base_val) + $past(req_op.index_val))
    else $error("indexed address wrong");

  ea_idx_zero_a: assert property (
    accept && req_op.indexed && req_op.base_f == ZERO_REG
    |=> ea_q == $past(req_op.index_val))
    else $error("zero base indexed address wrong");

  dbl_copy_a: assert property (
    resp_fire && op_q.dbl
    |=> fpr_wr_valid && fpr_wr.data == $past(mem_resp_data)
        && fpr_wr.tgt == op_q.tgt)
    else $error("double load not copied");

  upd_write_a: assert property (
    fpr_wr_valid |-> gpr_wr_valid == op_q.update
                     && gpr_wr.data == ea_q && gpr_wr.sel == op_q.base_f)
    else $error("update writeback wrong");

  req_addr_a: assert property (
    mem_req_valid |-> mem_req.addr == ea_q && mem_req.dbl == op_q.dbl)
    else $error("memory request mismatch");

  sp_norm_a: assert property (
    fpr_wr_valid && !op_q.dbl && fpla_classify(word_q) == CLS_NORM
    |-> fpr_wr.data == {word_q[31:30], {3{~word_q[30]}}, word_q[29:0],
                        29'h0})
    else $error("normalized conversion wrong");

  sp_special_a: assert property (
    fpr_wr_valid && !op_q.dbl && fpla_classify(word_q) == CLS_SPECIAL
    |-> fpr_wr.data == {word_q[31:30], {3{word_q[30]}}, word_q[29:0],
                        29'h0})
    else $error("special conversion wrong");

  sp_denorm_a: assert property (
    fpr_wr_valid && !op_q.dbl && fpla_classify(word_q) == CLS_DENORM
    |-> fpr_wr.data[63] == word_q[31] && fpr_wr.data[62:52] < 11'h381
        && fpr_wr.data[62:52] > 11'h369)
    else $error("denormal conversion wrong");

  cvt_bound_a: assert property (
    cvt_start |-> ##[1:25] cvt_done)
    else $error("normalization too slow");

  assist_raise_a: assert property (
    resp_fire && !op_q.dbl && resp_cls == CLS_DENORM && assist_en
    |=> assist_exc && !fpr_wr_valid && !gpr_wr_valid)
    else $error("assist exception missing");

  assist_gate_a: assert property (
    assist_exc |-> $past(assist_en) && !$past(op_q.dbl))
    else $error("assist exception without cause");

  exc_dbl_a: assert property (
    resp_fire && op_q.dbl |=> !assist_exc)
    else $error("double load raised assist");

  // shift count is recovered from the written exponent
  sp_denorm_frac_a: assert property (
    fpr_wr_valid && !op_q.dbl && fpla_classify(word_q) == CLS_DENORM
    |-> {1'b1, fpr_wr.data[51:29]}
          == ({1'b0, word_q[22:0]} << (11'h381 - fpr_wr.data[62:52]))
        && fpr_wr.data[28:0] == 29'h0)
    else $error("denormal fraction wrong");

  cvt_idle_a: assert property (
    cvt_start |-> !cvt_busy)
    else $error("converter started while busy");

  cvt_owner_a: assert property (
    cvt_done |-> st_q == ST_CVT)
    else $error("conversion result not awaited");

  pulse_pair_a: assert property (
    gpr_wr_valid |-> fpr_wr_valid)
    else $error("base write without load write");

  one_load_a: assert property (
    accept |=> !req_ready)
    else $error("second load accepted");

  mem_hold_a: assert property (
    mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req))
    else $error("memory request dropped");

  dbl_update_c: cover property (
    resp_fire && op_q.dbl && op_q.update ##1 gpr_wr_valid);
  sp_denorm_c: cover property (
    cvt_start && resp_cls == CLS_DENORM ##[1:25] fpr_wr_valid);
  assist_c: cover property (assist_exc);
  idx_zero_c: cover property (
    accept && req_op.indexed && req_op.base_f == ZERO_REG);
  issue_stall_c: cover property (mem_req_valid && !mem_req_ready);

endmodule : fpla_load_unit

// >>> tb/fpla_mem_model.sv
// Purpose: memory side model returning one load word per request
// Assumes: one request outstanding, word and latency set by the bench
// Notes: data lines show inverted junk while no word is offered
`timescale 1ns/1ps
module fpla_mem_model
  import fpla_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mem_req_valid,
  input wire fpla_mem_req_s mem_req,
  output logic mem_req_ready,
  output logic mem_resp_valid,
  output logic [63:0] mem_resp_data,
  input wire logic mem_resp_ready,
  input wire logic [63:0] rd_data,
  input wire logic [3:0] lat,
  output fpla_mem_req_s seen_q
);
  logic pend_q;
  logic [3:0] cnt_q;
  logic hold_q;
  // odd latency settings also stall the request for one cycle
  assign mem_req_ready = !lat[0] || hold_q;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      hold_q <= 1'b0;
    else
      hold_q <= mem_req_valid && !mem_req_ready;
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_q <= 1'b0;
      cnt_q <= 4'h0;
      seen_q <= '0;
      mem_resp_valid <= 1'b0;
      mem_resp_data <= 64'h0;
    end
    else
    begin
      if (mem_req_valid && mem_req_ready)
      begin
        pend_q <= 1'b1;
        cnt_q <= lat;
        seen_q <= mem_req;
      end
      else if (pend_q && cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
      else if (pend_q && !mem_resp_valid)
      begin
        mem_resp_valid <= 1'b1;
        mem_resp_data <= rd_data;
      end
      if (mem_resp_valid && mem_resp_ready)
      begin
        mem_resp_valid <= 1'b0;
        pend_q <= 1'b0;
        mem_resp_data <= ~mem_resp_data;
      end
    end
  end
endmodule : fpla_mem_model

// >>> tb/tb_top.sv
// Purpose: self-checking bench of the float load datapath
// Assumes: memory model answers each request once
// Notes: expectations come from reference functions written here
`timescale 1ns/1ps
module tb_top
  import fpla_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic assist_en = 1'b0;
  logic req_valid = 1'b0;
  fpla_op_s req_op = '0;
  logic req_ready, mem_req_valid, mem_req_ready, mem_resp_valid;
  logic mem_resp_ready, fpr_wr_valid, gpr_wr_valid, assist_exc;
  fpla_mem_req_s mem_req, seen;
  logic [63:0] mem_resp_data;
  logic [63:0] mem_data = 64'h0;
  logic [3:0] lat = 4'h0;
  fpla_fpr_wr_s fpr_wr;
  fpla_gpr_wr_s gpr_wr;
  int errors = 0;
  int n_compared = 0;

  always #5 clk_sys = ~clk_sys;

  fpla_load_unit fpla_load_unit_i (.clk_sys(clk_sys), .nrst(nrst),
    .assist_en(assist_en), .req_valid(req_valid), .req_op(req_op),
    .req_ready(req_ready), .mem_req_valid(mem_req_valid),
    .mem_req(mem_req), .mem_req_ready(mem_req_ready),
    .mem_resp_valid(mem_resp_valid), .mem_resp_data(mem_resp_data),
    .mem_resp_ready(mem_resp_ready), .fpr_wr_valid(fpr_wr_valid),
    .fpr_wr(fpr_wr), .gpr_wr_valid(gpr_wr_valid), .gpr_wr(gpr_wr),
    .assist_exc(assist_exc));

  fpla_mem_model fpla_mem_model_i (.clk_sys(clk_sys), .nrst(nrst),
    .mem_req_valid(mem_req_valid), .mem_req(mem_req),
    .mem_req_ready(mem_req_ready), .mem_resp_valid(mem_resp_valid),
    .mem_resp_data(mem_resp_data), .mem_resp_ready(mem_resp_ready),
    .rd_data(mem_data), .lat(lat), .seen_q(seen));

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic fpla_op_s mk(input int dbl, input int idx,
    input int upd, input logic [4:0] bf, input logic [15:0] disp,
    input logic [31:0] bv, input logic [31:0] iv);
    fpla_op_s o;
    o = '{dbl != 0, idx != 0, upd != 0, 5'h07, bf, 5'h03, disp, bv, iv};
    return o;
  endfunction : mk

  function automatic logic [31:0] ea_of(input fpla_op_s o);
    logic [31:0] b;
    b = (o.base_f == 5'h00) ? 32'h0 : o.base_val;
    return o.indexed ? b + o.index_val : b + {{16{o.disp[15]}}, o.disp};
  endfunction : ea_of

  function automatic logic [63:0] cvt(input logic [31:0] w);
    logic [23:0] m;
    int e;
    if (w[30:23] != 8'h00 && w[30:23] != 8'hff)
      return {w[31:30], {3{~w[30]}}, w[29:0], 29'h0};
    if (w[30:23] == 8'h00 && w[22:0] != 23'h0)
    begin
      m = {1'b0, w[22:0]};
      e = -126;
      while (!m[23])
      begin
        m = m << 1;
        e--;
      end
      return {w[31], 11'(e + 1023), m[22:0], 29'h0};
    end
    return {w[31:30], {3{w[30]}}, w[29:0], 29'h0};
  endfunction : cvt

  task automatic run_load(input fpla_op_s op, input logic [63:0] d,
                          input int ae);
    int n;
    logic exc;
    exc = ae && !op.dbl && d[30:23] == 8'h00 && d[22:0] != 23'h0;
    @(posedge clk_sys);
    assist_en <= (ae != 0);
    req_op <= op;
    mem_data <= d;
    req_valid <= 1'b1;
    n = 0;
    do
      @(negedge clk_sys);
    while (req_ready !== 1'b1 && ++n < 50);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    n = 0;
    do
      @(negedge clk_sys);
    while (fpr_wr_valid !== 1'b1 && assist_exc !== 1'b1 && ++n < 60);
    chk("mem addr", ea_of(op), seen.addr);
    chk("mem dbl", op.dbl, seen.dbl);
    chk("assist", exc, assist_exc);
    chk("fpr valid", !exc, fpr_wr_valid);
    chk("gpr valid", op.update && !exc, gpr_wr_valid);
    if (exc)
      return;
    chk("fpr data", op.dbl ? d : cvt(d[31:0]), fpr_wr.data);
    chk("fpr tgt", op.tgt, fpr_wr.tgt);
    if (op.update)
    begin
      chk("gpr data", ea_of(op), gpr_wr.data);
      chk("gpr sel", op.base_f, gpr_wr.sel);
    end
  endtask : run_load

  task automatic t_addr();
    run_load(mk(1, 0, 0, 5'h04, 16'hfff0, 32'h1000, 0),
             64'h0123456789abcdef, 0);
    run_load(mk(1, 0, 1, 5'h00, 16'h7fff, 32'h5555aaaa, 0),
             64'hfedcba9876543210, 0);
    run_load(mk(1, 0, 1, 5'h09, 16'h0010, 32'hfffffff8, 0),
             64'h8000000000000001, 0);
    $display("test addr done");
  endtask : t_addr

  task automatic t_index();
    run_load(mk(0, 1, 1, 5'h05, 16'h0, 32'h80000000, 32'h80000004),
             64'ha5a5a5a53f800000, 0);
    run_load(mk(1, 1, 1, 5'h00, 16'h0, 32'h12345678, 32'h2000),
             64'h3ff0000000000000, 0);
    run_load(mk(0, 1, 0, 5'h00, 16'h0, 32'h1, 32'h40), 64'h0, 0);
    $display("test index done");
  endtask : t_index

  task automatic t_reset();
    @(posedge clk_sys);
    nrst <= 1'b0;
    @(negedge clk_sys);
    chk("rst ready", 1'b1, req_ready);
    chk("rst mem valid", 1'b0, mem_req_valid);
    chk("rst fpr valid", 1'b0, fpr_wr_valid);
    chk("rst gpr valid", 1'b0, gpr_wr_valid);
    chk("rst assist", 1'b0, assist_exc);
    chk("rst fpr data", 64'h0, fpr_wr.data);
    @(posedge clk_sys);
    nrst <= 1'b1;
    $display("test reset done");
  endtask : t_reset

  task automatic t_conv();
    logic [31:0] w [9] = '{32'h3f800000, 32'hc0490fdb, 32'h00800000,
      32'h7f7fffff, 32'h00000000, 32'h80000000, 32'h7f800000,
      32'hff800000, 32'h7fc00001};
    foreach (w[i])
      run_load(mk(0, 0, 0, 5'h02, 16'h8, 32'h100, 0),
               {32'h5a5a5a5a, w[i]}, 0);
    $display("test conv done");
  endtask : t_conv

  task automatic t_denorm();
    logic [31:0] w [3] = '{32'h00000001, 32'h00400000, 32'h807fffff};
    lat <= 4'h3;
    foreach (w[i])
      run_load(mk(0, 0, 1, 5'h06, 16'h4, 32'h200, 0),
               {32'hffffffff, w[i]}, 0);
    lat <= 4'h0;
    $display("test denorm done");
  endtask : t_denorm

  task automatic t_assist();
    run_load(mk(0, 0, 1, 5'h06, 16'h4, 32'h300, 0), 64'h1, 1);
    run_load(mk(0, 0, 1, 5'h06, 16'h4, 32'h300, 0),
             64'h40490fdb, 1);
    run_load(mk(0, 1, 0, 5'h06, 16'h0, 32'h300, 4), 64'h0, 1);
    $display("test assist done");
  endtask : t_assist

  initial
  begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_addr();
    t_index();
    t_reset();
    t_conv();
    t_denorm();
    t_assist();
    give_verdict();
  end

  // whole run needs well under 2000 cycles
  initial
  begin
    #200000;
    errors++;
    give_verdict();
  end
endmodule : tb_top
